// ### core/lbc_core.v
// Local bus control: bus cycle sequencer, selects, hold, reset, test float,
// wait gate, non-maskable interrupt latch and power-down with wake delay.
// Assumes one clock where each cycle is one output-clock state, and a core
// that holds its request until done.
//
// Contract
// - Lower and upper selects go low for memory cycles inside their programmed range.
// - Lock output goes low to mark a bus cycle that must not be interrupted.
// - No hold grant while the lock output is asserted.
// - Read strobe low during reads; addressed device drives data.
// - Write strobe low while write data valid; addressed device captures it.
// - Cycle ends only with ready high, unless the select ignores ready.
// - Reset aborts any cycle, initialises state, drives pins known, raises reset out.
// - Reset out stays high as long as reset input is low.
// - Cycle type is encoded on three active-low status outputs.
// - Test strap low during reset floats every output and two-way pin except the crystal drive.
// - Test strap pin weakly pulled high while reset is asserted.
// - Crystal drive pin keeps driving in float test mode.
// - Coprocessor select goes low when the coprocessor is accessed.
// - Wait instruction suspends while wait gate high; resumes when sampled low.
// - Rising non-maskable interrupt is latched and serviced as type 2.
// - Power-down on halt with sleep bit set; left on interrupt or reset.
// - Interrupt exit waits the wake delay before clocks run; reset exit does not.
// - Address latch strobe high during the address phase of each cycle.
// - While hold acknowledge is high, data bus and controls float.
// - Hold is granted only at instruction boundaries outside a lock prefix.
// - Transfer width is encoded on address bit 0 and the upper byte enable.
`timescale 1ns/10ps
`include "lbc_regs.vh"

module lbc_core #(
  parameter [19:0] BOOT_ADDR = 20'hFFFF0            // Address of the first fetch
) (
  input  wire        CLK,                           // Clock, 50 MHz
  input  wire        RSTN,                          // Asynchronous reset, active low
  input  wire        CE,                            // Clock enable, freezes all state
  input  wire [7:0]  REG_ADDR,                      // Register byte address
  input  wire [31:0] REG_WDATA,                     // Register write data
  input  wire        REG_WR,                        // Register write strobe
  input  wire        REG_RD,                        // Register read strobe
  output reg  [31:0] REG_RDATA,                     // Register read data, next cycle
  input  wire        REQ_VALID,                     // Core bus request, held until done
  input  wire [2:0]  REQ_TYPE,                      // Cycle type code
  input  wire [19:0] REQ_ADDR,                      // Cycle address
  input  wire [1:0]  REQ_XFER,                      // Transfer width code
  input  wire [15:0] REQ_WDATA,                     // Write data
  input  wire        REQ_LOCK,                      // Cycle is under a lock prefix
  input  wire        REQ_COPRO,                     // Cycle targets the coprocessor
  input  wire        INSN_BOUNDARY,                 // Core sits at an instruction boundary
  input  wire        WAIT_INSN,                     // Core executes the wait instruction
  input  wire        NMI_ACK,                       // Core took the latched interrupt
  output reg         REQ_DONE,                      // Request finished, one-cycle pulse
  output reg  [15:0] REQ_RDATA,                     // Read data, valid with done
  output reg         WAIT_SUSPEND,                  // Core must stall for the wait gate
  output reg         NMI_PEND,                      // Latched interrupt pending
  output reg  [7:0]  NMI_TYPE,                      // Interrupt type of pending request
  output reg         CORE_CLK_EN,                   // Internal clocks run
  output reg  [15:0] AD_O,                          // Address/data out
  output reg  [15:0] AD_OE,                         // Address/data drive enables
  input  wire [15:0] AD_I,                          // Address/data in
  output reg  [3:0]  ADDR_HI,                       // Address bits 19..16
  output reg         CTRL_OE,                       // Drive enable of control outputs
  output reg         ALE,                           // Address latch strobe
  output reg         UBE_N,                         // Upper byte enable, active low
  output reg         RD_N,                          // Read strobe, active low
  output reg         WR_N,                          // Write strobe, active low
  output reg         CYCLE_TYPE_BIT0,               // Cycle type bit 0, active low
  output reg         CYCLE_TYPE_BIT1,               // Cycle type bit 1, active low
  output reg         CYCLE_TYPE_BIT2,               // Cycle type bit 2, active low
  output reg         LOCK_N,                        // Bus lock, active low
  output reg         LCS_N,                         // Lower memory select, active low
  output reg         UCS_N,                         // Upper memory select, active low
  output reg         NCS_N,                         // Coprocessor select, active low
  input  wire        READY,                         // Cycle ready, active high
  input  wire        HOLD,                          // External bus request
  output reg         HLDA,                          // Hold acknowledge
  output reg         RESOUT,                        // Reset indicator, active high
  input  wire        TEST_STRAP_N,                  // Float test strap, active low
  output reg         TEST_STRAP_PULL,               // Weak pull-up on the strap pin
  output reg         XTAL_DRV_OE,                   // Crystal drive pin enable
  input  wire        WAIT_GATE,                     // Wait gate, high suspends
  input  wire        XFER_REQ,                      // Coprocessor transfer request
  input  wire        NMI                            // Non-maskable interrupt, active high
);

  // ****************************************
  // States
  // ****************************************
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_DATA = 3'h2;
  localparam [2:0] S_WAIT = 3'h3;
  localparam [2:0] S_HOLD = 3'h4;
  localparam [2:0] S_PDWN = 3'h5;
  localparam [2:0] S_WAKE = 3'h6;

  function is_mem;
    input [2:0] ty;
    begin
      is_mem = (ty == `LBC_CY_FETCH) || (ty == `LBC_CY_MRD) || (ty == `LBC_CY_MWR);
    end
  endfunction

  function is_read;
    input [2:0] ty;
    begin
      is_read = (ty == `LBC_CY_FETCH) || (ty == `LBC_CY_MRD) || (ty == `LBC_CY_IORD) ||
                (ty == `LBC_CY_INTA);
    end
  endfunction

  reg [2:0]                 st_q;
  reg [`LBC_CTRL_W-1:0]     ctrl_q;
  reg [`LBC_BLK_W-1:0]      lcs_end_q;
  reg [`LBC_BLK_W-1:0]      ucs_start_q;
  reg [`LBC_WAKE_W-1:0]     wake_dly_q;
  reg [`LBC_WAKE_W-1:0]     wake_cnt_q;
  reg                       boot_q;
  reg                       float_q;
  reg                       nmi_prev_q;
  reg [2:0]                 cy_type_q;
  reg [19:0]                cy_addr_q;
  reg [1:0]                 cy_xfer_q;
  reg [15:0]                cy_wdata_q;
  reg                       cy_lock_q;
  reg                       cy_copro_q;
  reg                       cy_ign_q;

  // ****************************************
  // Next cycle selection
  // ****************************************
  wire       start_boot = boot_q;
  wire [2:0] nx_type    = start_boot ? `LBC_CY_FETCH : REQ_TYPE;
  wire [19:0] nx_addr   = start_boot ? BOOT_ADDR : REQ_ADDR;
  wire       nx_mem     = is_mem(nx_type);
  wire       nx_lcs     = nx_mem && (nx_addr[19:10] <= lcs_end_q);
  wire       nx_ucs     = nx_mem && (nx_addr[19:10] >= ucs_start_q);
  wire       nx_ign     = (nx_lcs && ctrl_q[`LBC_CTRL_IGN_LCS]) ||
                          (nx_ucs && ctrl_q[`LBC_CTRL_IGN_UCS]);
  // Granting only with no locked request and at a boundary keeps locked sequences whole
  wire       grant_ok   = HOLD && INSN_BOUNDARY && !REQ_LOCK && LOCK_N;
  wire       nmi_rise   = NMI && !nmi_prev_q;
  wire       pins_on    = !float_q;

  // ****************************************
  // Bus sequencer
  // ****************************************
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_q            <= S_IDLE;
      boot_q          <= 1'b1;
      float_q         <= 1'b0;
      RESOUT          <= 1'b1;
      TEST_STRAP_PULL <= 1'b1;
      XTAL_DRV_OE     <= 1'b1;
      cy_type_q       <= `LBC_CY_IDLE;
      cy_addr_q       <= 20'h00000;
      cy_xfer_q       <= `LBC_XF_WORD;
      cy_wdata_q      <= 16'h0000;
      cy_lock_q       <= 1'b0;
      cy_copro_q      <= 1'b0;
      cy_ign_q        <= 1'b0;
      wake_cnt_q      <= {`LBC_WAKE_W{1'b0}};
      REQ_DONE        <= 1'b0;
      REQ_RDATA       <= 16'h0000;
      CORE_CLK_EN     <= 1'b1;
      AD_O            <= 16'h0000;
      AD_OE           <= 16'h0000;
      ADDR_HI         <= 4'h0;
      CTRL_OE         <= 1'b1;
      ALE             <= 1'b0;
      UBE_N           <= 1'b1;
      RD_N            <= 1'b1;
      WR_N            <= 1'b1;
      CYCLE_TYPE_BIT0 <= 1'b1;
      CYCLE_TYPE_BIT1 <= 1'b1;
      CYCLE_TYPE_BIT2 <= 1'b1;
      LOCK_N          <= 1'b1;
      LCS_N           <= 1'b1;
      UCS_N           <= 1'b1;
      NCS_N           <= 1'b1;
      HLDA            <= 1'b0;
    end else if (CE) begin
      REQ_DONE <= 1'b0;
      XTAL_DRV_OE <= 1'b1;
      if (RESOUT) begin
        // Strap is caught at the first edge after release, while it is still pulled high
        float_q         <= !TEST_STRAP_N;
        RESOUT          <= 1'b0;
        TEST_STRAP_PULL <= 1'b0;
        CTRL_OE         <= TEST_STRAP_N;
      end else begin
        case (st_q)
          S_IDLE: begin
            if (grant_ok && !start_boot) begin
              st_q    <= S_HOLD;
              HLDA    <= 1'b1;
              CTRL_OE <= 1'b0;
            // Done still stands on the edge where the core drops its request
            end else if (start_boot || (REQ_VALID && !WAIT_SUSPEND && !REQ_DONE)) begin
              st_q            <= S_ADDR;
              boot_q          <= 1'b0;
              cy_type_q       <= nx_type;
              cy_addr_q       <= nx_addr;
              cy_xfer_q       <= start_boot ? `LBC_XF_WORD : REQ_XFER;
              cy_wdata_q      <= REQ_WDATA;
              cy_lock_q       <= !start_boot && REQ_LOCK;
              cy_copro_q      <= !start_boot && REQ_COPRO;
              cy_ign_q        <= nx_ign;
              ALE             <= 1'b1;
              AD_O            <= {nx_addr[15:1],
                                  start_boot ? 1'b0 : REQ_XFER[1]};
              AD_OE           <= {16{pins_on}};
              ADDR_HI         <= nx_addr[19:16];
              UBE_N           <= start_boot ? 1'b0 : REQ_XFER[0];
              CYCLE_TYPE_BIT0 <= nx_type[0];
              CYCLE_TYPE_BIT1 <= nx_type[1];
              CYCLE_TYPE_BIT2 <= nx_type[2];
              LOCK_N          <= !(!start_boot && REQ_LOCK);
              LCS_N           <= !nx_lcs;
              UCS_N           <= !nx_ucs;
              NCS_N           <= !(!start_boot && REQ_COPRO);
            end
          end
          S_ADDR: begin
            st_q <= S_DATA;
            ALE  <= 1'b0;
            if (is_read(cy_type_q)) begin
              AD_OE <= 16'h0000;
              RD_N  <= cy_type_q == `LBC_CY_HALT;
            end else begin
              AD_O  <= cy_wdata_q;
              WR_N  <= cy_type_q == `LBC_CY_HALT;
            end
            if (cy_type_q == `LBC_CY_HALT) begin
              AD_OE <= 16'h0000;
              RD_N  <= 1'b1;
              WR_N  <= 1'b1;
            end
          end
          S_DATA, S_WAIT: begin
            // One ready sample per state; a low sample costs exactly one wait state
            if (READY || cy_ign_q) begin
              st_q            <= S_IDLE;
              REQ_DONE        <= 1'b1;
              REQ_RDATA       <= AD_I;
              RD_N            <= 1'b1;
              WR_N            <= 1'b1;
              AD_OE           <= 16'h0000;
              CYCLE_TYPE_BIT0 <= 1'b1;
              CYCLE_TYPE_BIT1 <= 1'b1;
              CYCLE_TYPE_BIT2 <= 1'b1;
              LOCK_N          <= 1'b1;
              LCS_N           <= 1'b1;
              UCS_N           <= 1'b1;
              NCS_N           <= 1'b1;
              UBE_N           <= 1'b1;
              if ((cy_type_q == `LBC_CY_HALT) && ctrl_q[`LBC_CTRL_SLEEP]) begin
                st_q        <= S_PDWN;
                CORE_CLK_EN <= 1'b0;
              end
            end else begin
              st_q <= S_WAIT;
            end
          end
          S_HOLD: begin
            if (!HOLD) begin
              st_q    <= S_IDLE;
              HLDA    <= 1'b0;
              CTRL_OE <= pins_on;
            end
          end
          S_PDWN: begin
            if (nmi_rise) begin
              st_q       <= S_WAKE;
              wake_cnt_q <= wake_dly_q;
            end
          end
          S_WAKE: begin
            if (wake_cnt_q == {`LBC_WAKE_W{1'b0}}) begin
              st_q        <= S_IDLE;
              CORE_CLK_EN <= 1'b1;
            end else begin
              wake_cnt_q <= wake_cnt_q - 1'b1;
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Wait gate, interrupt latch
  // ****************************************
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      nmi_prev_q   <= 1'b0;
      NMI_PEND     <= 1'b0;
      NMI_TYPE     <= 8'h00;
      WAIT_SUSPEND <= 1'b0;
    end else if (CE) begin
      nmi_prev_q   <= NMI;
      WAIT_SUSPEND <= WAIT_INSN && WAIT_GATE;
      // A new edge in the clearing cycle must not be lost, so the set wins
      if (nmi_rise) begin
        NMI_PEND <= 1'b1;
        NMI_TYPE <= `LBC_NMI_TYPE;
      end else if (NMI_ACK) begin
        NMI_PEND <= 1'b0;
      end
    end
  end

  // ****************************************
  // Register port
  // ****************************************
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_q      <= `LBC_CTRL_RST;
      lcs_end_q   <= `LBC_LCS_END_RST;
      ucs_start_q <= `LBC_UCS_START_RST;
      wake_dly_q  <= `LBC_WAKE_DLY_RST;
      REG_RDATA   <= 32'h00000000;
    end else if (CE) begin
      if (REG_WR) begin
        case (REG_ADDR)
          `LBC_OFS_CTRL:      ctrl_q      <= REG_WDATA[`LBC_CTRL_W-1:0];
          `LBC_OFS_LCS_END:   lcs_end_q   <= REG_WDATA[`LBC_BLK_W-1:0];
          `LBC_OFS_UCS_START: ucs_start_q <= REG_WDATA[`LBC_BLK_W-1:0];
          `LBC_OFS_WAKE_DLY:  wake_dly_q  <= REG_WDATA[`LBC_WAKE_W-1:0];
          default:            ctrl_q      <= ctrl_q;
        endcase
      end
      REG_RDATA <= 32'h00000000;
      if (REG_RD) begin
        case (REG_ADDR)
          `LBC_OFS_CTRL:      REG_RDATA <= {29'h0, ctrl_q};
          `LBC_OFS_LCS_END:   REG_RDATA <= {22'h0, lcs_end_q};
          `LBC_OFS_UCS_START: REG_RDATA <= {22'h0, ucs_start_q};
          `LBC_OFS_WAKE_DLY:  REG_RDATA <= {16'h0, wake_dly_q};
          `LBC_OFS_STATUS:    REG_RDATA <= {24'h0, float_q, WAIT_SUSPEND,
                                            XFER_REQ, NMI_PEND, !LOCK_N, HLDA,
                                            st_q == S_WAKE, st_q == S_PDWN};
          default:            REG_RDATA <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // lbc_core

// ### core/lbc_regs.vh
// Register offsets, field positions and reset values of the local bus control block.
// Included by the block's design file only; holds definitions, no logic.
`ifndef LBC_REGS_VH
`define LBC_REGS_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define LBC_ADDR_W          8
`define LBC_OFS_CTRL        8'h00
`define LBC_OFS_LCS_END     8'h04
`define LBC_OFS_UCS_START   8'h08
`define LBC_OFS_WAKE_DLY    8'h0C
`define LBC_OFS_STATUS      8'h10

// ****************************************
// Control register fields
// ****************************************
`define LBC_CTRL_SLEEP      0
`define LBC_CTRL_IGN_LCS    1
`define LBC_CTRL_IGN_UCS    2
`define LBC_CTRL_W          3
`define LBC_CTRL_RST        3'h0

// ****************************************
// Select ranges, in 1 KiB blocks of the 20-bit address
// ****************************************
`define LBC_BLK_W           10
`define LBC_LCS_END_RST     10'h000
`define LBC_UCS_START_RST   10'h3FF

// ****************************************
// Wake delay, in clock cycles
// ****************************************
`define LBC_WAKE_W          16
`define LBC_WAKE_DLY_RST    16'h0100

// ****************************************
// Status register fields
// ****************************************
`define LBC_ST_PDOWN        0
`define LBC_ST_WAKING       1
`define LBC_ST_HLDA         2
`define LBC_ST_LOCK         3
`define LBC_ST_NMI          4
`define LBC_ST_XREQ         5
`define LBC_ST_SUSP         6
`define LBC_ST_FLOAT        7

// ****************************************
// Cycle type codes, bit2..bit0 as driven on the pins
// ****************************************
`define LBC_CY_INTA         3'h0
`define LBC_CY_IORD         3'h1
`define LBC_CY_IOWR         3'h2
`define LBC_CY_HALT         3'h3
`define LBC_CY_FETCH        3'h4
`define LBC_CY_MRD          3'h5
`define LBC_CY_MWR          3'h6
`define LBC_CY_IDLE         3'h7

// ****************************************
// Transfer width codes, (address bit 0, upper byte enable)
// ****************************************
`define LBC_XF_WORD         2'h0
`define LBC_XF_EVEN         2'h1
`define LBC_XF_ODD          2'h2
`define LBC_XF_REFRESH      2'h3

`define LBC_NMI_TYPE        8'h02

`endif

// ### verif/lbc_core_properties.sv
// Checker for the local bus control block, bound to every lbc_core instance.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/10ps
module lbc_checker (
  input wire logic        CLK,             // Clock
  input wire logic        RSTN,            // Reset, active low
  input wire logic        ALE,             // Address strobe
  input wire logic        RD_N,            // Read strobe
  input wire logic        WR_N,            // Write strobe
  input wire logic        CYCLE_TYPE_BIT0, // Status bit 0
  input wire logic        CYCLE_TYPE_BIT1, // Status bit 1
  input wire logic        CYCLE_TYPE_BIT2, // Status bit 2
  input wire logic        LOCK_N,          // Bus lock
  input wire logic        LCS_N,           // Lower select
  input wire logic        UCS_N,           // Upper select
  input wire logic        READY,           // Cycle ready
  input wire logic        HLDA,            // Hold acknowledge
  input wire logic        CTRL_OE,         // Control drive enable
  input wire logic [15:0] AD_OE,           // Bus drive enables
  input wire logic        XTAL_DRV_OE,     // Crystal drive enable
  input wire logic        NMI,             // Interrupt input
  input wire logic        NMI_PEND,        // Interrupt pending
  input wire logic [7:0]  NMI_TYPE,        // Interrupt type
  input wire logic        RESOUT           // Reset indicator
);
  wire [2:0] code = {CYCLE_TYPE_BIT2, CYCLE_TYPE_BIT1, CYCLE_TYPE_BIT0};
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  a_ale_pulse: assert property (ALE |=> !ALE)
    else $error("address strobe longer than one cycle");
  a_read_code: assert property ($fell(RD_N) |-> $past(ALE) && code inside {3'h0, 3'h1, 3'h4, 3'h5})
    else $error("read strobe outside a read cycle");
  a_write_code: assert property ($fell(WR_N) |-> $past(ALE) && code inside {3'h2, 3'h6})
    else $error("write strobe outside a write cycle");
  a_ready_end: assert property (($rose(RD_N) || $rose(WR_N)) |-> $past(READY) || !$past(LCS_N) || !$past(UCS_N))
    else $error("cycle ended without ready");
  a_lock_grant: assert property ($rose(HLDA) |-> $past(LOCK_N))
    else $error("hold granted under lock");
  a_hold_float: assert property (HLDA |-> !CTRL_OE && AD_OE == 16'h0000)
    else $error("bus driven during hold");
  a_lock_cycle: assert property (!LOCK_N |-> code != 3'h7)
    else $error("lock outside a bus cycle");
  a_select_mem: assert property (!(LCS_N && UCS_N) |-> code inside {3'h4, 3'h5, 3'h6})
    else $error("select low outside a memory cycle");
  a_xtal_drive: assert property (XTAL_DRV_OE)
    else $error("crystal drive released");
  a_nmi_latch: assert property ($rose(NMI) |=> NMI_PEND && NMI_TYPE == 8'h02)
    else $error("interrupt not latched as type 2");
  a_reset_exit: assert property ($rose(RSTN) |=> !RESOUT)
    else $error("reset indicator stuck after release");
  cover property ($rose(HLDA));
  cover property ($fell(RD_N));
  cover property ($rose(NMI_PEND));
endmodule // lbc_checker

bind lbc_core lbc_checker i_lbc_checker (.CLK(CLK), .RSTN(RSTN), .ALE(ALE), .RD_N(RD_N),
  .WR_N(WR_N), .CYCLE_TYPE_BIT0(CYCLE_TYPE_BIT0), .CYCLE_TYPE_BIT1(CYCLE_TYPE_BIT1),
  .CYCLE_TYPE_BIT2(CYCLE_TYPE_BIT2), .LOCK_N(LOCK_N), .LCS_N(LCS_N), .UCS_N(UCS_N),
  .READY(READY), .HLDA(HLDA), .CTRL_OE(CTRL_OE), .AD_OE(AD_OE), .XTAL_DRV_OE(XTAL_DRV_OE),
  .NMI(NMI), .NMI_PEND(NMI_PEND), .NMI_TYPE(NMI_TYPE), .RESOUT(RESOUT));

// ### verif/lbc_mem_model.sv
// Far side: memory or I/O device with a wait-state generator on ready.
// Assumes the low address byte sits on the bus while the address strobe is high.
`timescale 1ns/10ps
module lbc_mem_model (
  input  wire logic        CLK,   // Clock
  input  wire logic        ALE,   // Address strobe
  input  wire logic        RD_N,  // Read strobe
  input  wire logic        WR_N,  // Write strobe
  input  wire logic [15:0] AD_O,  // Bus from the block
  input  wire logic [3:0]  WAITS, // Wait states per cycle
  output wire logic [15:0] AD_I,  // Bus to the block
  output wire logic        READY  // Cycle ready
);
  logic [15:0] mem [0:255];
  logic [15:0] last_q = 16'h0000;
  logic [7:0]  addr_q = 8'h00;
  logic [3:0]  cnt_q  = 4'h0;
  assign READY = !ALE && cnt_q >= WAITS;
  // Released bus shows the inverse of its last value so stale data never matches
  assign AD_I = !RD_N ? mem[addr_q] : ~last_q;
  always @(posedge CLK) begin
    last_q <= AD_I;
    if (ALE) begin
      addr_q <= AD_O[7:0];
      cnt_q <= 4'h0;
    end else if (cnt_q != 4'hF) begin
      cnt_q <= cnt_q + 4'h1;
    end
    if (!WR_N && READY) mem[addr_q] <= AD_O;
  end
endmodule // lbc_mem_model

// ### verif/tb_local_bus_control_pins.sv
// Bench for the local bus control block against a wait-state memory model.
// Assumes a 50 MHz clock; reset held for 8 cycles at the start.
`timescale 1ns/10ps
module tb_local_bus_control_pins;
  logic        clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0;
  logic        req_lock = 1'b0, insn_b = 1'b1, wait_insn = 1'b0, nmi_ack = 1'b0, hold = 1'b0;
  logic        strap_n = 1'b1, wait_gate = 1'b0, xfer_req = 1'b0, nmi = 1'b0, copro = 1'b0;
  logic [7:0]  reg_addr = 8'h00, nmi_type;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, st;
  logic [2:0]  req_type = 3'h0;
  logic [19:0] req_addr = 20'h0;
  logic [15:0] req_wdata = 16'h0, req_rdata, ad_o, ad_oe, ad_i, d;
  logic [3:0]  waits = 4'h0;
  logic        req_done, wait_susp, nmi_pend, clk_en, ctrl_oe, ale, rd_n, wr_n, lock_n;
  logic        lcs_n, ucs_n, ready, hlda, resout, pull, xtal_oe, ct0, ct1, ct2, ncs_n;
  int          bad_count = 0, compares = 0, n;
  always #10 clk = ~clk;
  lbc_core i_lbc_core (.CLK(clk), .RSTN(rstn), .CE(1'b1), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .REQ_VALID(req_valid), .REQ_TYPE(req_type), .REQ_ADDR(req_addr), .REQ_XFER(2'h0),
    .REQ_WDATA(req_wdata), .REQ_LOCK(req_lock), .REQ_COPRO(copro), .INSN_BOUNDARY(insn_b),
    .WAIT_INSN(wait_insn), .NMI_ACK(nmi_ack), .REQ_DONE(req_done), .REQ_RDATA(req_rdata),
    .WAIT_SUSPEND(wait_susp), .NMI_PEND(nmi_pend), .NMI_TYPE(nmi_type), .CORE_CLK_EN(clk_en),
    .AD_O(ad_o), .AD_OE(ad_oe), .AD_I(ad_i), .ADDR_HI(), .CTRL_OE(ctrl_oe), .ALE(ale),
    .UBE_N(), .RD_N(rd_n), .WR_N(wr_n), .CYCLE_TYPE_BIT0(ct0), .CYCLE_TYPE_BIT1(ct1),
    .CYCLE_TYPE_BIT2(ct2), .LOCK_N(lock_n), .LCS_N(lcs_n), .UCS_N(ucs_n), .NCS_N(ncs_n),
    .READY(ready), .HOLD(hold), .HLDA(hlda), .RESOUT(resout), .TEST_STRAP_N(strap_n),
    .TEST_STRAP_PULL(pull), .XTAL_DRV_OE(xtal_oe), .WAIT_GATE(wait_gate),
    .XFER_REQ(xfer_req), .NMI(nmi));
  lbc_mem_model i_lbc_mem_model (.CLK(clk), .ALE(ale), .RD_N(rd_n), .WR_N(wr_n),
    .AD_O(ad_o), .WAITS(waits), .AD_I(ad_i), .READY(ready));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Each access starts one edge late so a strobe is never driven twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    check(reg_rdata, exp);
  endtask
  task automatic bus(input logic [2:0] ty, input logic [19:0] a, input logic [15:0] wd);
    logic [2:0] code;
    code = 3'h7;
    n = 0;
    @(posedge clk);
    req_type <= ty;
    req_addr <= a;
    req_wdata <= wd;
    req_valid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (ale === 1'b1) code = {ct2, ct1, ct0};
    end while (req_done !== 1'b1 && n < 40);
    req_valid <= 1'b0;
    d = req_rdata;
    check(code, ty);
    check(req_done, 1'b1);
  endtask
  task automatic t_regs;
    rd(8'h04, 32'h000);
    rd(8'h08, 32'h3FF);
    rd(8'h0C, 32'h100);
    rd(8'h14, 32'h0);
    wr(8'h0C, 32'h4);
    rd(8'h0C, 32'h4);
  endtask
  task automatic t_cycles;
    bus(3'h6, 20'h00010, 16'h1234);
    waits <= 4'h2;
    bus(3'h5, 20'h00010, 16'h0000);
    check(d, 16'h1234);
    check(n, 6);
    wr(8'h00, 32'h2);
    bus(3'h5, 20'h00010, 16'h0000);
    check(n, 4);
    wr(8'h00, 32'h0);
    waits <= 4'h0;
    for (int t = 0; t < 7; t++) bus(t[2:0], 20'h00020, 16'h00A5);
  endtask
  task automatic t_hold;
    req_lock <= 1'b1;
    hold <= 1'b1;
    bus(3'h5, 20'h00010, 16'h0000);
    check(hlda, 1'b0);
    req_lock <= 1'b0;
    xfer_req <= 1'b1;
    repeat (3) @(posedge clk);
    check(hlda, 1'b1);
    check(ctrl_oe, 1'b0);
    hold <= 1'b0;
    repeat (3) @(posedge clk);
    check(hlda, 1'b0);
    rd(8'h10, 32'h20);
    xfer_req <= 1'b0;
  endtask
  task automatic t_wait;
    wait_insn <= 1'b1;
    wait_gate <= 1'b1;
    repeat (3) @(posedge clk);
    check(wait_susp, 1'b1);
    wait_gate <= 1'b0;
    repeat (3) @(posedge clk);
    check(wait_susp, 1'b0);
    wait_insn <= 1'b0;
  endtask
  task automatic t_pdown;
    wr(8'h00, 32'h1);
    bus(3'h3, 20'h00000, 16'h0000);
    repeat (2) @(posedge clk);
    check(clk_en, 1'b0);
    nmi <= 1'b1;
    for (n = 0; n < 30 && clk_en !== 1'b1; n++) @(posedge clk);
    check(n >= 5 && n <= 8, 1'b1);
    check(nmi_type, 8'h02);
    nmi <= 1'b0;
    nmi_ack <= 1'b1;
    repeat (2) @(posedge clk);
    nmi_ack <= 1'b0;
    @(posedge clk);
    check(nmi_pend, 1'b0);
    wr(8'h00, 32'h0);
  endtask
  task automatic t_reset;
    waits <= 4'hF;
    req_type <= 3'h5;
    copro <= 1'b1;
    req_valid <= 1'b1;
    repeat (4) @(posedge clk);
    check(rd_n, 1'b0);
    check(ncs_n, 1'b0);
    strap_n <= 1'b0;
    rstn <= 1'b0;
    #1;
    check(rd_n, 1'b1);
    check(resout, 1'b1);
    check(pull, 1'b1);
    repeat (8) @(posedge clk);
    req_valid <= 1'b0;
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    check(resout, 1'b0);
    check({ct2, ct1, ct0}, 3'h4);
    check({ctrl_oe, ad_oe}, 17'h0);
    check(xtal_oe, 1'b1);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (12) @(posedge clk);
    t_regs;
    t_cycles;
    t_hold;
    t_wait;
    t_pdown;
    t_reset;
    close_out;
  end
  initial begin
    #100000;
    bad_count++;
    close_out;
  end
endmodule // tb_local_bus_control_pins
